// >>> sim/twi_link_sva.sv
/* Bus-level checker for the two-wire link between master and slave.
   Assumes the bench wires it to the signals of the bus interface. */
`timescale 1ns/1ps
module twi_link_sva (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic m_scl_o,
    input wire logic m_scl_oe,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic s_scl_o,
    input wire logic s_scl_oe,
    input wire logic s_sda_o,
    input wire logic s_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic       scl_q;
    logic       sda_q;
    logic [3:0] cnt_q;
    // Conditions and clock rises seen against the previous sample.
    wire        rise_w  = scl & ~scl_q;
    wire        start_w = scl & scl_q & sda_q & ~sda;
    wire        stop_w  = scl & scl_q & ~sda_q & sda;
    wire  [3:0] wrap_w  = (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
    wire  [3:0] cnt_d   = start_w ? 4'h0 : (rise_w ? wrap_w : cnt_q);
    // Rises counted per nine-clock byte, so conditions fall on a boundary.
    always_ff @(posedge core_clk) begin
        scl_q <= srst ? 1'b1 : scl;
        sda_q <= srst ? 1'b1 : sda;
        cnt_q <= srst ? 4'h0 : cnt_d;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    property p_open_drain; !(m_scl_o | m_sda_o | s_scl_o | s_sda_o);
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("a party drove a line high");
    property p_master_start; start_w |-> m_sda_oe && !s_sda_oe; endproperty
    a_master_start: assert property (p_master_start)
        else $error("start not made by the master");
    property p_stop_idle; stop_w |=> scl [*4]; endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("clock line left high after stop broke early");
    property p_slave_release;
        stop_w |-> !s_sda_oe ##1 (!s_scl_oe && !s_sda_oe) [*8];
    endproperty
    a_slave_release: assert property (p_slave_release)
        else $error("slave drove a line after stop");
    property p_slave_sda_low; $changed(s_sda_oe) |-> !scl; endproperty
    a_slave_sda_low: assert property (p_slave_sda_low)
        else $error("slave moved data while clock high");
    property p_slave_hold; $rose(s_scl_oe) |-> !scl; endproperty
    a_slave_hold: assert property (p_slave_hold)
        else $error("slave cut a clock high phase short");
    property p_master_clock; $fell(scl) |-> m_scl_oe; endproperty
    a_master_clock: assert property (p_master_clock)
        else $error("clock fall not made by the master");
    property p_boundary; (start_w || stop_w) |-> cnt_q <= 4'h1; endproperty
    a_boundary: assert property (p_boundary)
        else $error("condition inside a byte");
    c_start: cover property (start_w);
    c_stretch: cover property ($rose(s_scl_oe));
    c_ack: cover property (rise_w && cnt_q == 4'h8 && s_sda_oe);
endmodule

// >>> sim/two_wire_serial_slave_protocol_bench.sv
/* Bench joining both ends of the two-wire link on one bus.
   Assumes the bus interface and both end modules from src/. */
`timescale 1ns/1ps
`include "twi_consts.svh"
`define CHK(n, g, e) begin comparisons++; if ((g) !== (e)) begin \
    bad_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module two_wire_serial_slave_protocol_bench;
    logic       core_clk, srst, cmd_valid, cmd_start, cmd_stop;
    logic       cmd_read, cmd_ack, ten_bit_mode, gen_call_en, crb;
    logic       tx_valid, nk, cmd_ready, rsp_valid, rsp_nack, m_busy;
    logic       tx_ready, rx_valid, gen_call_hit, s_busy, is_tx;
    logic [7:0] cmd_wdata, tx_data, rsp_rdata, rx_data, r, d;
    logic [9:0] own_addr, a;
    logic [7:0] tx_mem [5];
    logic [7:0] rxq [$];
    int         tx_idx, bad_count, comparisons, seed = 54160;
    twi_bus_if bus ();
    twi_master #(.QTR_CYC(4)) u_twi_master (.core_clk(core_clk),
        .srst(srst), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
        .cmd_read(cmd_read), .cmd_ack(cmd_ack), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack),
        .busy(m_busy));
    twi_slave u_twi_slave (.core_clk(core_clk), .srst(srst), .bus(bus),
        .own_addr(own_addr), .ten_bit_mode(ten_bit_mode),
        .gen_call_en(gen_call_en), .clock_release_bit(crb),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid), .gen_call_hit(gen_call_hit),
        .busy(s_busy), .is_transmitter(is_tx));
    twi_link_sva u_twi_link_sva (.core_clk(core_clk), .srst(srst),
        .m_scl_o(bus.m_scl_o), .m_scl_oe(bus.m_scl_oe),
        .m_sda_o(bus.m_sda_o), .m_sda_oe(bus.m_sda_oe),
        .s_scl_o(bus.s_scl_o), .s_scl_oe(bus.s_scl_oe),
        .s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe),
        .scl(bus.scl), .sda(bus.sda));
    // Clock at 25 MHz.
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Bytes are offered at random moments, so the slave must stretch.
    always @(posedge core_clk) begin
        if (tx_valid !== 1'b1) tx_valid <= 1'($random(seed));
        else if (tx_ready === 1'b1) begin
            tx_valid <= 1'b0;
            tx_idx <= tx_idx + 1;
            tx_data <= tx_mem[tx_idx + 1];
        end
        if (rx_valid === 1'b1) rxq.push_back(rx_data);
    end
    function automatic logic [7:0] hdr(input logic [9:0] ad, input logic rd);
        return {`TWI_TEN_HDR, ad[9:8], rd};
    endfunction
    // One master command; returns after its response pulse.
    task automatic xfer(input logic st, sp, rd, ak, input logic [7:0] wd);
        int n;
        @(posedge core_clk);
        {cmd_valid, cmd_start, cmd_stop} <= {1'b1, st, sp};
        {cmd_read, cmd_ack, cmd_wdata} <= {rd, ak, wd};
        n = 0;
        do @(negedge core_clk); while (cmd_ready !== 1'b1 && ++n < 5000);
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        n = 0;
        do @(negedge core_clk); while (rsp_valid !== 1'b1 && ++n < 9000);
        if (rsp_valid !== 1'b1) bad_count++;
        r = rsp_rdata;
        nk = rsp_nack;
        // A lost response counts as a mismatch; then let the ninth fall land.
        repeat (16) @(negedge core_clk);
    endtask
    task automatic rx_is(input logic [7:0] e);
        logic [7:0] v;
        v = (rxq.size() > 0) ? rxq.pop_front() : 8'hXX;
        `CHK("rx_data", v, e)
    endtask
    task automatic load_tx;
        foreach (tx_mem[i]) tx_mem[i] = 8'($random(seed));
        @(posedge core_clk);
        tx_idx <= 0;
        tx_data <= tx_mem[0];
    endtask
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // A hang counts as a mismatch; the whole run needs far fewer cycles.
    initial begin
        repeat (40000) @(posedge core_clk);
        bad_count++;
        conclude();
    end
    // Main sequence.
    initial begin
        {cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_ack} = 5'h00;
        {tx_valid, ten_bit_mode, gen_call_en, crb, srst} = 5'h03;
        {cmd_wdata, tx_data, tx_idx, own_addr} = '0;
        a = {3'h0, 2'h1, 5'($random(seed))};
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        own_addr <= a;
        repeat (3) @(posedge core_clk);
        xfer(1, 0, 0, 1, {a[6:0], 1'b0});
        `CHK("addr_nack", nk, 1'b0)
        for (int i = 0; i < 3; i++) begin
            d = 8'($random(seed));
            xfer(0, i == 2, 0, 1, d);
            `CHK("data_nack", nk, 1'b0)
            rx_is(d);
        end
        repeat (8) @(negedge core_clk);
        `CHK("slave_busy", s_busy, 1'b0)
        xfer(1, 0, 0, 1, {a[6:0] ^ 7'h01, 1'b0});
        `CHK("miss_nack", nk, 1'b1)
        repeat (8) @(negedge core_clk);
        `CHK("master_busy", m_busy, 1'b0)
        load_tx();
        xfer(1, 0, 0, 1, {a[6:0], 1'b1});
        `CHK("is_tx", is_tx, 1'b1)
        for (int i = 0; i < 2; i++) begin
            xfer(0, i == 1, 1, i == 0, 8'h00);
            `CHK("rd_data", r, tx_mem[i])
        end
        `CHK("tx_end", is_tx, 1'b0)
        @(posedge core_clk) gen_call_en <= 1'b1;
        xfer(1, 0, 0, 1, `TWI_GEN_CALL);
        `CHK("gc_hit", gen_call_hit, 1'b1)
        d = 8'($random(seed));
        xfer(0, 1, 0, 1, d);
        rx_is(d);
        @(posedge core_clk) gen_call_en <= 1'b0;
        xfer(1, 1, 0, 1, `TWI_GEN_CALL);
        `CHK("gc_off", nk, 1'b1)
        a = 10'($random(seed));
        @(posedge core_clk) ten_bit_mode <= 1'b1;
        own_addr <= a;
        xfer(1, 1, 0, 1, hdr(a, 1'b1));
        `CHK("hdr_rd_alone", nk, 1'b1)
        load_tx();
        xfer(1, 0, 0, 1, hdr(a, 1'b0));
        `CHK("hdr_nack", nk, 1'b0)
        d = 8'($random(seed));
        xfer(0, 0, 0, 1, a[7:0]);
        xfer(0, 0, 0, 1, d);
        rx_is(d);
        xfer(1, 0, 0, 1, hdr(a, 1'b1));
        `CHK("rs_tx", is_tx, 1'b1)
        xfer(0, 1, 1, 0, 8'h00);
        `CHK("rs_data", r, tx_mem[0])
        @(posedge core_clk) ten_bit_mode <= 1'b0;
        xfer(1, 0, 0, 1, {a[6:0], 1'b0});
        @(posedge core_clk) crb <= 1'b0;
        fork
            xfer(0, 1, 0, 1, d);
            begin
                repeat (120) @(negedge core_clk);
                `CHK("stretch", bus.s_scl_oe, 1'b1)
                @(posedge core_clk);
                crb <= 1'b1;
            end
        join
        rx_is(d);
        conclude();
    end
endmodule

// >>> src/twi_bus_if.sv
/*
 * The two open-drain bus lines joining master and slave.
 * Assumes pull-ups: a line is low only while some enabled driver
 * drives zero, and reads high otherwise.
 */
`timescale 1ns/1ps

interface twi_bus_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_scl_o;
    logic s_scl_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;

    // Wired-AND of both parties; the pull-up wins when nobody pulls.
    assign scl = ~((m_scl_oe & ~m_scl_o) | (s_scl_oe & ~s_scl_o));
    assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

    modport master (
        input  scl, sda,
        output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe
    );
    modport slave (
        input  scl, sda,
        output s_scl_o, s_scl_oe, s_sda_o, s_sda_oe
    );
endinterface

// >>> src/twi_consts.svh
/*
 * Shared constants for both ends of the two-wire serial link.
 * Assumes a 25 MHz core clock and open-drain lines with pull-ups.
 */
`ifndef TWI_CONSTS_SVH
`define TWI_CONSTS_SVH

`define TWI_CLK_NS      40
`define TWI_QTR_NS      2500
`define TWI_QTR_CYC     ((`TWI_QTR_NS + `TWI_CLK_NS - 1) / `TWI_CLK_NS)
`define TWI_SYNC_IDLE   2'h3
`define TWI_BYTE_BITS   4'h8
`define TWI_LAST_BIT    4'h7
`define TWI_CNT_ZERO    4'h0
`define TWI_TEN_HDR     5'h1E
`define TWI_GEN_CALL    8'h00
`define TWI_RD_FILL     8'hFF
`define TWI_PH_SCL_LOW  2'h0
`define TWI_PH_SDA_SET  2'h1
`define TWI_PH_SCL_REL  2'h2
`define TWI_PH_SCL_HIGH 2'h3

`endif

// >>> src/twi_master.sv
/*
 * Master end of the two-wire link: one byte per command, with
 * optional start before and stop after, and stretch-aware clocking.
 * Assumes the bus interface resolves the wired-AND lines.
 */
`timescale 1ns/1ps
`include "twi_consts.svh"

module twi_master #(
    parameter int QTR_CYC = `TWI_QTR_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        srst,
    twi_bus_if.master        bus,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_start,
    input  wire logic        cmd_stop,
    input  wire logic        cmd_read,
    input  wire logic        cmd_ack,
    input  wire logic [7:0]  cmd_wdata,
    output logic             rsp_valid,
    output logic [7:0]       rsp_rdata,
    output logic             rsp_nack,
    output logic             busy
);

    twi_pkg::master_state_t state_q;

    logic [1:0]  scl_sync_q;
    logic [1:0]  sda_sync_q;
    logic [15:0] qcnt_q;
    logic [1:0]  ph_q;
    logic [3:0]  bit_cnt_q;
    logic [8:0]  tx9_q;
    logic [8:0]  rx9_q;
    logic        read_q;
    logic        stop_q;
    logic        scl_oe_q;
    logic        sda_oe_q;
    logic        rsp_valid_q;
    logic [7:0]  rsp_rdata_q;
    logic        rsp_nack_q;

    // Two-stage synchronisers on the bus lines.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            scl_sync_q <= `TWI_SYNC_IDLE;
            sda_sync_q <= `TWI_SYNC_IDLE;
        end else begin
            scl_sync_q <= {scl_sync_q[0], bus.scl};
            sda_sync_q <= {sda_sync_q[0], bus.sda};
        end
    end

    wire scl_s = scl_sync_q[1];
    wire sda_s = sda_sync_q[1];

    // Quarter-bit enable from a free-running divider.
    wire qtick = qcnt_q == 16'(QTR_CYC - 1);

    always_ff @(posedge core_clk) begin
        if (srst || qtick)
            qcnt_q <= 16'h0000;
        else
            qcnt_q <= qcnt_q + 16'h0001;
    end

    // The high phase waits while the slave holds SCL low.
    wire high_ph  = ph_q == `TWI_PH_SCL_HIGH;
    wire adv      = qtick & ~(high_ph & ~scl_s);
    wire in_hold  = (state_q == twi_pkg::MS_HOLD)
                  & (ph_q == `TWI_PH_SDA_SET);
    wire idle_st  = state_q == twi_pkg::MS_IDLE;
    wire take     = cmd_valid & (idle_st | in_hold);
    wire last_bit = bit_cnt_q == `TWI_BYTE_BITS;
    // A refused write byte ends the transfer at once.
    wire end_now  = stop_q | (~read_q & sda_s);

    // Sequencer: start, bit and stop states walk four quarters per bus bit.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q     <= twi_pkg::MS_IDLE;
            ph_q        <= `TWI_PH_SCL_LOW;
            bit_cnt_q   <= `TWI_CNT_ZERO;
            tx9_q       <= 9'h1FF;
            rx9_q       <= 9'h000;
            read_q      <= 1'b0;
            stop_q      <= 1'b0;
            scl_oe_q    <= 1'b0;
            sda_oe_q    <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= 8'h00;
            rsp_nack_q  <= 1'b0;
        end else begin
            rsp_valid_q <= 1'b0;
            if (take) begin
                read_q    <= cmd_read;
                stop_q    <= cmd_stop;
                bit_cnt_q <= `TWI_CNT_ZERO;
                ph_q      <= `TWI_PH_SCL_LOW;
                if (cmd_read)
                    tx9_q <= {`TWI_RD_FILL, ~cmd_ack};
                else
                    tx9_q <= {cmd_wdata, 1'b1};
                if (cmd_start || idle_st)
                    state_q <= twi_pkg::MS_START;
                else
                    state_q <= twi_pkg::MS_BIT;
            end else if (adv) begin
                ph_q <= ph_q + 2'h1;
                case (state_q)
                    twi_pkg::MS_START: begin
                        if (ph_q == `TWI_PH_SCL_LOW)
                            sda_oe_q <= 1'b0;
                        if (ph_q == `TWI_PH_SDA_SET)
                            scl_oe_q <= 1'b0;
                        if (high_ph) begin
                            sda_oe_q <= 1'b1;
                            state_q  <= twi_pkg::MS_BIT;
                        end
                    end
                    twi_pkg::MS_BIT: begin
                        if (ph_q == `TWI_PH_SCL_LOW)
                            scl_oe_q <= 1'b1;
                        if (ph_q == `TWI_PH_SDA_SET)
                            sda_oe_q <= ~tx9_q[8];
                        if (ph_q == `TWI_PH_SCL_REL)
                            scl_oe_q <= 1'b0;
                        if (high_ph) begin
                            rx9_q     <= {rx9_q[7:0], sda_s};
                            tx9_q     <= {tx9_q[7:0], 1'b1};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        if (high_ph && last_bit) begin
                            rsp_valid_q <= 1'b1;
                            rsp_rdata_q <= rx9_q[7:0];
                            rsp_nack_q  <= sda_s;
                            state_q     <= end_now ? twi_pkg::MS_STOP
                                                   : twi_pkg::MS_HOLD;
                        end
                    end
                    twi_pkg::MS_HOLD: begin
                        // The bus is kept by holding SCL low.
                        scl_oe_q <= 1'b1;
                        ph_q     <= `TWI_PH_SDA_SET;
                    end
                    twi_pkg::MS_STOP: begin
                        if (ph_q == `TWI_PH_SCL_LOW)
                            scl_oe_q <= 1'b1;
                        if (ph_q == `TWI_PH_SDA_SET)
                            sda_oe_q <= 1'b1;
                        if (ph_q == `TWI_PH_SCL_REL)
                            scl_oe_q <= 1'b0;
                        if (high_ph) begin
                            sda_oe_q <= 1'b0;
                            state_q  <= twi_pkg::MS_IDLE;
                        end
                    end
                    twi_pkg::MS_IDLE: begin
                        ph_q <= `TWI_PH_SCL_LOW;
                    end
                    default: begin
                        state_q <= twi_pkg::MS_IDLE;
                    end
                endcase
            end
        end
    end

    // Open-drain pins only ever pull low.
    assign bus.m_scl_o  = 1'b0;
    assign bus.m_sda_o  = 1'b0;
    assign bus.m_scl_oe = scl_oe_q;
    assign bus.m_sda_oe = sda_oe_q;
    assign cmd_ready    = idle_st | in_hold;
    assign rsp_valid    = rsp_valid_q;
    assign rsp_rdata    = rsp_rdata_q;
    assign rsp_nack     = rsp_nack_q;
    assign busy         = ~idle_st;

endmodule

// >>> src/twi_pkg.sv
/*
 * Types shared by both ends of the two-wire link.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package twi_pkg;

    // Gray codes along idle, address, acknowledge, data.
    typedef enum logic [3:0] {
        SL_IDLE      = 4'h0,
        SL_ADDR      = 4'h1,
        SL_ADDR_ACK  = 4'h3,
        SL_RX        = 4'h2,
        SL_RX_ACK    = 4'h6,
        SL_TX        = 4'h7,
        SL_TX_ACK    = 4'h5,
        SL_ADDR2     = 4'h4,
        SL_ADDR2_ACK = 4'hC,
        SL_IGNORE    = 4'hD
    } slave_state_t;

    // Gray codes along idle, start, bit, hold, stop.
    typedef enum logic [2:0] {
        MS_IDLE  = 3'h0,
        MS_START = 3'h1,
        MS_BIT   = 3'h3,
        MS_HOLD  = 3'h2,
        MS_STOP  = 3'h6
    } master_state_t;

endpackage

// >>> src/twi_slave.sv
/*
 * Slave end of the two-wire link: condition detection, short and
 * long addressing, general call, acknowledge and clock stretching.
 * Assumes the bus interface resolves the wired-AND lines and that
 * the user side runs on core_clk.
 */
`timescale 1ns/1ps
`include "twi_consts.svh"

module twi_slave (
    input  wire logic        core_clk,
    input  wire logic        srst,
    twi_bus_if.slave         bus,
    input  wire logic [9:0]  own_addr,
    input  wire logic        ten_bit_mode,
    input  wire logic        gen_call_en,
    input  wire logic        clock_release_bit,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    output logic [7:0]       rx_data,
    output logic             rx_valid,
    output logic             gen_call_hit,
    output logic             busy,
    output logic             is_transmitter
);

    twi_pkg::slave_state_t state_q;
    twi_pkg::slave_state_t state_d;
    twi_pkg::slave_state_t route_q;
    twi_pkg::slave_state_t route_d;

    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic       scl_p_q;
    logic       sda_p_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic       tx_have_q;
    logic       ten_match_q;
    logic       mst_ack_q;
    logic       scl_oe_q;
    logic       sda_oe_q;
    logic [7:0] rx_data_q;
    logic       rx_valid_q;
    logic       gc_q;

    // Two-stage synchronisers; only the second stage is looked at.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            scl_sync_q <= `TWI_SYNC_IDLE;
            sda_sync_q <= `TWI_SYNC_IDLE;
        end else begin
            scl_sync_q <= {scl_sync_q[0], bus.scl};
            sda_sync_q <= {sda_sync_q[0], bus.sda};
        end
    end

    wire scl_s = scl_sync_q[1];
    wire sda_s = sda_sync_q[1];

    // Previous synchronised levels, for edge and condition finding.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // Conditions are SDA edges seen while SCL stays high.
    wire scl_rise  = scl_s & ~scl_p_q;
    wire scl_fall  = ~scl_s & scl_p_q;
    wire scl_hi    = scl_s & scl_p_q;
    wire start_det = scl_hi & sda_p_q & ~sda_s;
    wire stop_det  = scl_hi & ~sda_p_q & sda_s;

    // Byte framing: eight bits then the acknowledge clock.
    wire receiving = (state_q == twi_pkg::SL_ADDR)
                   | (state_q == twi_pkg::SL_ADDR2)
                   | (state_q == twi_pkg::SL_RX);
    wire byte_done = scl_fall & (bit_cnt_q == `TWI_BYTE_BITS);

    // Address decode on the first byte after a start, and on the low byte of a long address.
    wire dir_read  = shift_q[0];
    wire hdr10     = shift_q[7:3] == `TWI_TEN_HDR;
    wire match7    = ~ten_bit_mode
                   & (shift_q[7:1] == own_addr[6:0]);
    wire match_gc  = gen_call_en & (shift_q == `TWI_GEN_CALL);
    wire match_hdr = ten_bit_mode & hdr10
                   & (shift_q[2:1] == own_addr[9:8]);
    wire hdr_ok    = match_hdr & (~dir_read | ten_match_q);
    wire addr_ok   = match7 | match_gc | hdr_ok;
    wire match_lo  = shift_q == own_addr[7:0];

    // A read header reuses the low byte matched by the last write.
    wire to_tx     = dir_read & ~match_gc;
    wire to_addr2  = match_hdr & ~dir_read;

    // Address and receive ack states drive SDA low; a refused byte leaves it released.
    wire in_ack    = (state_q == twi_pkg::SL_ADDR_ACK)
                   | (state_q == twi_pkg::SL_ADDR2_ACK)
                   | (state_q == twi_pkg::SL_RX_ACK);
    wire in_tx     = state_q == twi_pkg::SL_TX;
    wire tx_bit    = in_tx & tx_have_q & ~shift_q[7];
    wire sda_oe_d  = in_ack | tx_bit;

    // Transmitter waits for a byte; receiver waits only when asked.
    wire tx_need   = in_tx & (bit_cnt_q == `TWI_CNT_ZERO) & ~tx_have_q;
    wire user_hold = ~clock_release_bit
                   & (in_tx | (state_q == twi_pkg::SL_RX));
    wire tx_settle = in_tx & scl_oe_q & (sda_oe_q ^ tx_bit);
    wire stretch   = tx_need | user_hold | tx_settle;
    // SCL is only grabbed while already low, so no false clock edge.
    wire scl_oe_d  = stretch & (scl_oe_q | ~scl_s);
    wire tx_take   = tx_valid & tx_need;

    // Next state; start and stop override every other event.
    always_comb begin
        state_d = state_q;
        route_d = route_q;
        if (start_det) begin
            state_d = twi_pkg::SL_ADDR;
        end else if (stop_det) begin
            state_d = twi_pkg::SL_IDLE;
        end else begin
            case (state_q)
                twi_pkg::SL_ADDR: begin
                    if (byte_done && addr_ok) begin
                        state_d = twi_pkg::SL_ADDR_ACK;
                        if (to_tx)
                            route_d = twi_pkg::SL_TX;
                        else if (to_addr2)
                            route_d = twi_pkg::SL_ADDR2;
                        else
                            route_d = twi_pkg::SL_RX;
                    end else if (byte_done) begin
                        state_d = twi_pkg::SL_IGNORE;
                    end
                end
                twi_pkg::SL_ADDR2: begin
                    if (byte_done && match_lo) begin
                        state_d = twi_pkg::SL_ADDR2_ACK;
                        route_d = twi_pkg::SL_RX;
                    end else if (byte_done) begin
                        state_d = twi_pkg::SL_IGNORE;
                    end
                end
                twi_pkg::SL_RX: begin
                    if (byte_done) begin
                        state_d = twi_pkg::SL_RX_ACK;
                        route_d = twi_pkg::SL_RX;
                    end
                end
                twi_pkg::SL_ADDR_ACK,
                twi_pkg::SL_ADDR2_ACK,
                twi_pkg::SL_RX_ACK: begin
                    if (scl_fall)
                        state_d = route_q;
                end
                twi_pkg::SL_TX: begin
                    if (scl_fall && tx_have_q
                        && bit_cnt_q == `TWI_LAST_BIT)
                        state_d = twi_pkg::SL_TX_ACK;
                end
                twi_pkg::SL_TX_ACK: begin
                    if (scl_fall && mst_ack_q)
                        state_d = twi_pkg::SL_TX;
                    else if (scl_fall)
                        state_d = twi_pkg::SL_IGNORE;
                end
                twi_pkg::SL_IDLE,
                twi_pkg::SL_IGNORE: begin
                    state_d = state_q;
                end
                default: begin
                    state_d = twi_pkg::SL_IDLE;
                end
            endcase
        end
    end

    // State, route and line drivers.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q  <= twi_pkg::SL_IDLE;
            route_q  <= twi_pkg::SL_RX;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            route_q  <= route_d;
            scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d;
        end
    end

    // Bit counter: receivers count rising edges, the sender falling.
    always_ff @(posedge core_clk) begin
        if (srst || start_det || state_d != state_q)
            bit_cnt_q <= `TWI_CNT_ZERO;
        else if (receiving && scl_rise)
            bit_cnt_q <= bit_cnt_q + 4'h1;
        else if (in_tx && tx_have_q && scl_fall)
            bit_cnt_q <= bit_cnt_q + 4'h1;
    end

    // Shift register, sampled on SCL high so SDA is settled.
    always_ff @(posedge core_clk) begin
        if (srst)
            shift_q <= `TWI_GEN_CALL;
        else if (receiving && scl_rise)
            shift_q <= {shift_q[6:0], sda_s};
        else if (tx_take)
            shift_q <= tx_data;
        else if (in_tx && tx_have_q && scl_fall)
            shift_q <= {shift_q[6:0], 1'b1};
    end

    // Transmit byte holder, cleared for each new byte.
    always_ff @(posedge core_clk) begin
        if (srst || start_det || state_q != twi_pkg::SL_TX)
            tx_have_q <= 1'b0;
        else if (tx_take)
            tx_have_q <= 1'b1;
    end

    // Master's answer to our byte, sampled while SCL is high.
    always_ff @(posedge core_clk) begin
        if (srst)
            mst_ack_q <= 1'b0;
        else if (state_q == twi_pkg::SL_TX_ACK && scl_rise)
            mst_ack_q <= ~sda_s;
    end

    // Long-address match lives until a stop or an address byte other than our long header.
    always_ff @(posedge core_clk) begin
        if (srst || stop_det)
            ten_match_q <= 1'b0;
        else if (state_q == twi_pkg::SL_ADDR2 && byte_done)
            ten_match_q <= match_lo;
        else if (state_q == twi_pkg::SL_ADDR && byte_done)
            ten_match_q <= ten_match_q & match_hdr;
    end

    // Received data and general call flag toward the user.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx_data_q  <= `TWI_GEN_CALL;
            rx_valid_q <= 1'b0;
            gc_q       <= 1'b0;
        end else begin
            rx_valid_q <= (state_q == twi_pkg::SL_RX) & byte_done;
            if ((state_q == twi_pkg::SL_RX) && byte_done)
                rx_data_q <= shift_q;
            if (start_det || stop_det)
                gc_q <= 1'b0;
            else if (state_q == twi_pkg::SL_ADDR && byte_done)
                gc_q <= match_gc;
        end
    end

    // Open-drain pins only ever pull low.
    assign bus.s_scl_o    = 1'b0;
    assign bus.s_sda_o    = 1'b0;
    assign bus.s_scl_oe   = scl_oe_q;
    assign bus.s_sda_oe   = sda_oe_q;
    assign tx_ready       = tx_need;
    assign rx_data        = rx_data_q;
    assign rx_valid       = rx_valid_q;
    assign gen_call_hit   = gc_q;
    assign busy           = state_q != twi_pkg::SL_IDLE;
    assign is_transmitter = in_tx | (state_q == twi_pkg::SL_TX_ACK);

endmodule
